// >>> reload_down_timer.sv
// Purpose: Two independent 16-bit reload down timers with interrupt and transfer request
// Assumes: Inputs synchronous to mclk per pin rule, but still triple-registered
// Notes:   Register port answers reads one cycle later; unmapped reads return zero
//          Channel n sits at n times the stride: control, reload, count (read only)
//          Shared status and mask words hold one bit per channel; status is write-one-clear
//          Control bit 0 starts on a 0-to-1 write and always reads back as zero
//          Control bit 8 reads back whether the channel is counting
//          A start written together with enable takes effect in that same write
//          Prescaler runs free, so the first period after a start may be short
//
// Functional notes
// - Each timer counts a clock chosen from three divided internal clocks or an event input.
// - A timer starts by a software trigger bit or, outside event mode, by the external trigger input.
// - A 16-bit underflow can raise an interrupt so the timer works as an interval timer.
// - In one-shot mode an underflow stops counting until the next trigger.
// - In reload mode an underflow copies the reload value into the counter and counting goes on.
// - Select codes 00, 01 and 10 choose internal clock mode, each a different period.
// - In internal clock mode the counter decrements once per selected tick, on mclk.
// - Starting happens on detection of a software trigger or, outside event mode, the configured edge of external trigger.
// - An underflow may request the automatic transfer service instead of an interrupt.
// - Two independent instances exist, each with own counter, reload and control.
//
// The address map and the strobed register port are this design's own decisions.

`timescale 1ns/1ps
`default_nettype none

module reload_down_timer
	import reload_timer_pkg::*;
#(
	parameter int NCH = NUM_CH
) (
	input  wire logic                mclk,
	input  wire logic                rst,
	input  wire logic [ADDR_W-1:0]   addr,
	input  wire logic [DATA_W-1:0]   wdata,
	input  wire logic                wr_stb,
	input  wire logic                rd_stb,
	output logic      [DATA_W-1:0]   rdata,
	input  wire logic [NCH-1:0]      ext_trigger,
	input  wire logic [NCH-1:0]      ext_event,
	output logic      [NCH-1:0]      underflow_out,
	output logic      [NCH-1:0]      xfer_req,
	output logic                     irq
);

	// Channel register address decode, reused for write and read paths
	function automatic logic hit(input logic [ADDR_W-1:0] a, input int ch,
		input logic [7:0] off);
		// Channel base is index times stride; offsets add within it
		hit = (a == ADDR_W'(int'(CH_STRIDE) * ch + int'(off)));
	endfunction

	// Shared prescaler: one free counter, taps give the three internal periods
	// Free running from reset, so taps are not aligned to any start
	logic [PRESC_W-1:0] presc_reg;
	logic [PRESC_W-1:0] presc_prev_reg;
	logic [2:0]         tick_int;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			presc_reg      <= '0;
			presc_prev_reg <= '0;
		end else begin
			presc_reg      <= presc_reg + PRESC_W'(1);
			presc_prev_reg <= presc_reg;
		end
	end

	// Falling edge of a tap marks one tick of that divided clock
	// A tap falls once per full period of its bit, so each tick is one clock wide
	assign tick_int[0] = presc_prev_reg[DIV_A_LOG2-1] & ~presc_reg[DIV_A_LOG2-1];
	assign tick_int[1] = presc_prev_reg[DIV_B_LOG2-1] & ~presc_reg[DIV_B_LOG2-1];
	assign tick_int[2] = presc_prev_reg[DIV_C_LOG2-1] & ~presc_reg[DIV_C_LOG2-1];

	// Interrupt bookkeeping shared by both channels
	logic [NCH-1:0] stat_reg;
	logic [NCH-1:0] mask_reg;
	logic [NCH-1:0] uf_evt;
	logic [NCH-1:0] pending;

	// Read-back views gathered from each channel
	logic [DATA_W-1:0] ctrl_rd   [NCH];
	logic [DATA_W-1:0] reload_rd [NCH];
	logic [DATA_W-1:0] count_rd  [NCH];

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : gen_ch
			// Per-channel registers
			logic [CTRL_W-1:0] ctrl_reg;
			logic [DATA_W-1:0] reload_reg;
			logic [DATA_W-1:0] count_reg;
			logic [2:0]        trig_sync_reg;
			logic [2:0]        evt_sync_reg;
			logic              sw_trig_prev_reg;
			timer_state_t      state_reg;
			logic              uf_out_reg;
			logic              xfer_reg;

			// Decoded fields and single-cycle strobes
			logic              sw_trig_bit;
			logic              ctrl_wr;
			logic              en_now;
			logic              running;
			logic [1:0]        csel;
			logic [1:0]        edge_sel;
			logic              ext_rise;
			logic              ext_fall;
			logic              ext_edge;
			logic              evt_rise;
			logic              sw_edge;
			logic              start;
			logic              tick;
			logic              count_zero;
			logic              uf;

			// Field views of the control word
			assign ctrl_wr  = wr_stb && hit(addr, g, OFF_CTRL);
			// Enable as it will stand after this edge, so one write can enable and start
			assign en_now   = ctrl_wr ? wdata[B_ENABLE] : ctrl_reg[B_ENABLE];
			assign running  = (state_reg == ST_COUNT);
			assign csel     = {ctrl_reg[B_CSEL_HI], ctrl_reg[B_CSEL_LO]};
			assign edge_sel = {ctrl_reg[B_EDGE_HI], ctrl_reg[B_EDGE_LO]};

			// Three-stage chain; only the second and third stages feed edge logic
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					trig_sync_reg <= '0;
				end else begin
					trig_sync_reg <= {trig_sync_reg[1:0], ext_trigger[g]};
				end
			end

			// Event pin chain, kept apart from the trigger chain
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					evt_sync_reg <= '0;
				end else begin
					evt_sync_reg <= {evt_sync_reg[1:0], ext_event[g]};
				end
			end

			// Edges seen between the last two stages, two clocks after the pin
			assign ext_rise = trig_sync_reg[1] & ~trig_sync_reg[2];
			assign ext_fall = ~trig_sync_reg[1] & trig_sync_reg[2];
			assign evt_rise = evt_sync_reg[1] & ~evt_sync_reg[2];

			// Configured edge of the external trigger; event mode ignores it
			always_comb begin
				case (edge_sel)
					EDGE_RISE: ext_edge = ext_rise;
					EDGE_FALL: ext_edge = ext_fall;
					EDGE_BOTH: ext_edge = ext_rise | ext_fall;
					default:   ext_edge = 1'b0;
				endcase
			end

			// Software trigger acts on its 0-to-1 write, so rewriting 1 does not restart
			assign sw_trig_bit = ctrl_wr & wdata[B_SW_TRIG];
			assign sw_edge     = sw_trig_bit & ~sw_trig_prev_reg;
			// A start while counting simply reloads, which gives a retrigger
			assign start = en_now & (sw_edge
				| (ext_edge & (csel != CSEL_EVENT)));

			// Count tick: an internal divided clock, or an event rising edge
			always_comb begin
				case (csel)
					CSEL_DIV_A: tick = tick_int[0];
					CSEL_DIV_B: tick = tick_int[1];
					CSEL_DIV_C: tick = tick_int[2];
					default:    tick = evt_rise;
				endcase
			end

			// Underflow is a tick seen at zero; a start in the same cycle takes priority
			assign count_zero = (count_reg == COUNT_RESET);
			assign uf         = running && tick && !start && count_zero;

			// Last written trigger bit, so only a 0-to-1 write starts the timer
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					sw_trig_prev_reg <= 1'b0;
				end else if (ctrl_wr) begin
					sw_trig_prev_reg <= wdata[B_SW_TRIG];
				end
			end

			// Control word; bit 0 is stored but never read back
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					ctrl_reg <= CTRL_RESET[CTRL_W-1:0];
				end else if (ctrl_wr) begin
					ctrl_reg <= wdata[CTRL_W-1:0];
				end
			end

			// Reload value; a new one takes effect at the next start or reload-mode underflow
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					reload_reg <= COUNT_RESET;
				end else if (wr_stb && hit(addr, g, OFF_RELOAD)) begin
					reload_reg <= wdata;
				end
			end

			// Run control; clearing enable halts the timer one clock after the write
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					state_reg <= ST_IDLE;
				end else begin
					case (state_reg)
						ST_IDLE: begin
							if (start) begin
								state_reg <= ST_COUNT;
							end
						end
						ST_COUNT: begin
							if (!ctrl_reg[B_ENABLE]) begin
								state_reg <= ST_IDLE;
							end else if (uf && !ctrl_reg[B_RELOAD_MODE]) begin
								state_reg <= ST_IDLE;
							end
						end
						// Unused encodings fall back to idle
						default: state_reg <= ST_IDLE;
					endcase
				end
			end

			// Counter: load on start, reload or park on underflow, else decrement on a tick
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					count_reg <= COUNT_RESET;
				end else if (start) begin
					count_reg <= reload_reg;
				end else if (uf) begin
					// Reload mode goes on without a gap; one-shot parks at all ones
					if (ctrl_reg[B_RELOAD_MODE]) begin
						count_reg <= reload_reg;
					end else begin
						count_reg <= '1; // Wraps to all ones, then holds
					end
				end else if (running && tick) begin
					count_reg <= count_reg - ONE16;
				end
			end

			// Underflow routed to interrupt or to the transfer request
			assign uf_evt[g] = uf & ~ctrl_reg[B_XFER_SEL];

			// Underflow pulse, one clock wide, a cycle after the event
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					uf_out_reg <= 1'b0;
				end else begin
					uf_out_reg <= uf;
				end
			end

			// Transfer request pulse; status stays clear when this path is chosen
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					xfer_reg <= 1'b0;
				end else begin
					xfer_reg <= uf & ctrl_reg[B_XFER_SEL];
				end
			end

			// Each channel drives only its own bit of the shared outputs
			assign underflow_out[g] = uf_out_reg;
			assign xfer_req[g]      = xfer_reg;

			// Read-back views; the trigger bit always reads zero
			assign ctrl_rd[g]   = {{(DATA_W-B_RUNNING-1){1'b0}},
				running, ctrl_reg[CTRL_W-1:1], 1'b0};
			assign reload_rd[g] = reload_reg;
			assign count_rd[g]  = count_reg;
		end
	endgenerate

	// Sticky status; a new underflow wins over a write-one clear
	// Writing one to a bit that is already clear does nothing
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stat_reg <= '0;
		end else if (wr_stb && addr == ADDR_W'(OFF_IRQ_STAT)) begin
			stat_reg <= (stat_reg & ~wdata[NCH-1:0]) | uf_evt;
		end else begin
			stat_reg <= stat_reg | uf_evt;
		end
	end

	// Mask bits let each channel onto the single interrupt line
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mask_reg <= '0;
		end else if (wr_stb && addr == ADDR_W'(OFF_IRQ_MASK)) begin
			mask_reg <= wdata[NCH-1:0];
		end
	end

	// Level output; stays up until software clears or masks every pending bit
	assign pending = stat_reg & mask_reg;
	assign irq     = |pending;

	// Read mux; unmapped addresses return zero
	logic [DATA_W-1:0] rdata_next;

	always_comb begin
		rdata_next = '0;
		if (addr == ADDR_W'(OFF_IRQ_STAT)) begin
			rdata_next = DATA_W'(stat_reg);
		end else if (addr == ADDR_W'(OFF_IRQ_MASK)) begin
			rdata_next = DATA_W'(mask_reg);
		end else begin
			// Channel windows do not overlap, so at most one arm matches
			for (int i = 0; i < NCH; i++) begin
				if (hit(addr, i, OFF_CTRL)) begin
					rdata_next = ctrl_rd[i];
				end else if (hit(addr, i, OFF_RELOAD)) begin
					rdata_next = reload_rd[i];
				end else if (hit(addr, i, OFF_COUNT)) begin
					rdata_next = count_rd[i];
				end
			end
		end
	end

	// Data valid only in the cycle after the read strobe
	// Zero outside the answer cycle keeps a shared read bus quiet
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else if (rd_stb) begin
			rdata <= rdata_next;
		end else begin
			rdata <= '0;
		end
	end

endmodule

`default_nettype wire

// >>> reload_timer_pkg.sv
// Purpose: Constants shared by the dual reload down timer
// Assumes: Single machine clock, simple strobe register port
// Notes:   Byte addresses of each channel's registers, field positions

package reload_timer_pkg;

	localparam int          ADDR_W         = 8;
	localparam int          DATA_W         = 16;
	localparam int          NUM_CH         = 2;

	// Per-channel register window: channel index times stride plus offset
	localparam logic [7:0]  CH_STRIDE      = 8'h10;
	localparam logic [7:0]  OFF_CTRL       = 8'h00;
	localparam logic [7:0]  OFF_RELOAD     = 8'h04;
	localparam logic [7:0]  OFF_COUNT      = 8'h08;
	localparam logic [7:0]  OFF_IRQ_STAT   = 8'h40;
	localparam logic [7:0]  OFF_IRQ_MASK   = 8'h44;

	// Control field positions
	localparam int          B_SW_TRIG      = 0;
	localparam int          B_ENABLE       = 1;
	localparam int          B_RELOAD_MODE  = 2;
	localparam int          B_XFER_SEL     = 3;
	localparam int          B_EDGE_LO      = 4;
	localparam int          B_EDGE_HI      = 5;
	localparam int          B_CSEL_LO      = 6;
	localparam int          B_CSEL_HI      = 7;
	localparam int          B_RUNNING      = 8;
	localparam int          CTRL_W         = 8;

	localparam logic [15:0] CTRL_RESET     = 16'h0000;
	localparam logic [15:0] COUNT_RESET    = 16'h0000;
	localparam logic [15:0] ONE16          = 16'h0001;

	// Count clock select codes
	localparam logic [1:0]  CSEL_DIV_A     = 2'h0;
	localparam logic [1:0]  CSEL_DIV_B     = 2'h1;
	localparam logic [1:0]  CSEL_DIV_C     = 2'h2;
	localparam logic [1:0]  CSEL_EVENT     = 2'h3;

	// Trigger edge codes
	localparam logic [1:0]  EDGE_NONE      = 2'h0;
	localparam logic [1:0]  EDGE_RISE      = 2'h1;
	localparam logic [1:0]  EDGE_FALL      = 2'h2;
	localparam logic [1:0]  EDGE_BOTH      = 2'h3;

	// Prescaler taps: tick every 2^n machine clocks
	localparam int          DIV_A_LOG2     = 1;
	localparam int          DIV_B_LOG2     = 3;
	localparam int          DIV_C_LOG2     = 5;
	localparam int          PRESC_W        = 6;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_COUNT
	} timer_state_t;

endpackage

// >>> reload_timer_monitor.sv
// Purpose: Port-level checks for the dual reload timer
// Assumes: One clock, asynchronous active-high reset
// Notes:   Bound into every instance of the timer
`timescale 1ns/1ps
`default_nettype none
module timer_check
	import reload_timer_pkg::*;
#(
	parameter int NCH = 2
) (
	input wire logic              mclk,
	input wire logic              rst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic              wr_stb,
	input wire logic              rd_stb,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic [NCH-1:0]    ext_trigger,
	input wire logic [NCH-1:0]    ext_event,
	input wire logic [NCH-1:0]    underflow_out,
	input wire logic [NCH-1:0]    xfer_req,
	input wire logic              irq
);
	// Single domain, so one default for every check
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// Read data only show in the cycle after a read strobe
	AST_RD_QUIET: assert property (!$past(rd_stb) |-> rdata == 16'h0000)
		else $error("read data outside the answer cycle");
	// Underflow pulses last one cycle; fastest divider still leaves a gap
	AST_UF0_PULSE: assert property (underflow_out[0] |=> !underflow_out[0])
		else $error("channel 0 underflow pulse too long");
	AST_UF1_PULSE: assert property (underflow_out[NCH-1] |=> !underflow_out[NCH-1])
		else $error("last channel underflow pulse too long");
	AST_XFER_PULSE: assert property (xfer_req[NCH-1] |=> !xfer_req[NCH-1])
		else $error("transfer request pulse too long");
	// A transfer request only ever rides on an underflow
	AST_XFER_UF: assert property ((xfer_req & ~underflow_out) == '0)
		else $error("transfer request without underflow");
	// Interrupt rises only from an underflow or a register write
	AST_IRQ_CAUSE: assert property ($rose(irq) |->
		$past(wr_stb) || (|underflow_out) || (|$past(underflow_out)))
		else $error("interrupt rose without a cause");
	AST_IRQ_HOLD: assert property (irq && !wr_stb |=> irq)
		else $error("interrupt dropped without a write");
	AST_MASK_OFF: assert property (wr_stb && addr == OFF_IRQ_MASK && wdata == 16'h0000
		|=> !irq)
		else $error("interrupt stayed up with all masked");
endmodule
bind reload_down_timer timer_check #(.NCH(NCH)) timer_check_i (
	.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
	.rd_stb(rd_stb), .rdata(rdata), .ext_trigger(ext_trigger), .ext_event(ext_event),
	.underflow_out(underflow_out), .xfer_req(xfer_req), .irq(irq));
`default_nettype wire

// >>> tb.sv
// Purpose: Self-checking bench for the dual reload timer
// Assumes: Register map and control layout of the package
// Notes:   Reads queue their expectation; a monitor compares
`timescale 1ns/1ps
`default_nettype none
module tb import reload_timer_pkg::*;;
	logic        mclk = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, rd_seen = 1'b0, irq;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wdata = 16'h0000, rdata, r, exq[$];
	logic [1:0]  ext_trigger = 2'h0, ext_event = 2'h0, underflow_out, xfer_req;
	int          miscompares = 0, compares = 0, seed = 51616, n, xfc = 0;
	int          ufc[2] = '{0, 0};
	int          lg[3] = '{DIV_A_LOG2, DIV_B_LOG2, DIV_C_LOG2};

	always #12.5 mclk = ~mclk;

	reload_down_timer #(.NCH(2)) reload_down_timer_i (.mclk(mclk), .rst(rst), .addr(addr),
		.wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.ext_trigger(ext_trigger), .ext_event(ext_event), .underflow_out(underflow_out),
		.xfer_req(xfer_req), .irq(irq));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Bus cycles: drive after an edge, release after the taking edge
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		exq.push_back(e);
		@(posedge mclk);
		rd_stb <= 1'b0;
	endtask
	task automatic chk_irq(input logic e);
		@(negedge mclk);
		chk({15'h0, irq}, {15'h0, e});
	endtask
	// First pass finds a pulse, second measures the spacing
	task automatic gap(input int c, output int g);
		for (int p = 0; p < 2; p++) begin
			g = 0;
			do begin
				@(negedge mclk);
				g++;
			end while (underflow_out[c] !== 1'b1 && g < 3000);
		end
	endtask
	task automatic close_out;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// Mid-cycle sampling keeps clear of the design's edge updates
	always @(posedge mclk) rd_seen <= rd_stb;
	always @(negedge mclk) begin
		if (rd_seen && exq.size() > 0) chk(rdata, exq.pop_front());
		for (int c = 0; c < 2; c++) if (underflow_out[c] === 1'b1) ufc[c]++;
		if (xfer_req[1] === 1'b1) xfc++;
	end

	// Whole plan needs well under this many cycles
	initial begin
		#(40000 * 25);
		miscompares++;
		close_out;
	end

	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		r = 16'h0002 + 16'($unsigned($random(seed)) % 8);
		rd(OFF_CTRL, CTRL_RESET);
		rd(CH_STRIDE + OFF_COUNT, COUNT_RESET);
		rd(8'h20, 16'h0000);
		wr(OFF_IRQ_MASK, 16'h0003);
		wr(OFF_RELOAD, r);
		// Reload period under each internal divider
		for (int s = 0; s < 3; s++) begin
			wr(OFF_CTRL, 16'h0000);
			wr(OFF_CTRL, 16'(s << 6) | 16'h0007);
			gap(0, n);
			chk(16'(n), 16'((r + 1) << lg[s]));
		end
		// Sticky status, masking, write-one-to-clear
		wr(OFF_CTRL, 16'h0000);
		chk_irq(1'b1);
		rd(OFF_IRQ_STAT, 16'h0001);
		wr(OFF_IRQ_MASK, 16'h0000);
		chk_irq(1'b0);
		wr(OFF_IRQ_STAT, 16'h0001);
		rd(OFF_IRQ_STAT, 16'h0000);
		wr(OFF_IRQ_MASK, 16'h0003);
		// One-shot on channel 1, transfer request in place of status
		wr(CH_STRIDE + OFF_RELOAD, r);
		ufc[1] = 0;
		xfc = 0;
		wr(CH_STRIDE + OFF_CTRL, 16'h000B);
		repeat (300) @(posedge mclk);
		chk(16'(ufc[1]), 16'h0001);
		chk(16'(xfc), 16'h0001);
		rd(OFF_IRQ_STAT, 16'h0000);
		rd(CH_STRIDE + OFF_COUNT, 16'hFFFF);
		// Every trigger edge code: a rising then a falling pin edge
		for (int e = 0; e < 4; e++) begin
			wr(OFF_CTRL, 16'(e << 4) | 16'h0002);
			ufc[0] = 0;
			repeat (2) begin
				ext_trigger[0] <= ~ext_trigger[0];
				repeat (100) @(posedge mclk);
			end
			chk(16'(ufc[0]), (e == 3) ? 16'h0002 : (e == 0) ? 16'h0000 : 16'h0001);
		end
		// Event counting, reload of two: three edges per underflow
		wr(CH_STRIDE + OFF_CTRL, 16'h0000);
		wr(CH_STRIDE + OFF_RELOAD, 16'h0002);
		wr(CH_STRIDE + OFF_CTRL, 16'h00C7);
		ufc[1] = 0;
		repeat (6) begin
			ext_event[1] <= 1'b1;
			repeat (3) @(posedge mclk);
			ext_event[1] <= 1'b0;
			repeat (3) @(posedge mclk);
		end
		repeat (10) @(posedge mclk);
		chk(16'(ufc[1]), 16'h0002);
		close_out;
	end
endmodule
`default_nettype wire
